// ---- core/wdl_regs.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef WDL_REGS_SVH
`define WDL_REGS_SVH
`define WDL_OFF_RELOAD 8'h00
`define WDL_OFF_EVCFG 8'h04
`define WDL_OFF_CTRL 8'h08
`define WDL_OFF_DECEN 8'h0C
`define WDL_OFF_PINCFG 8'h10
`define WDL_OFF_ISTAT 8'h14
`define WDL_OFF_IMASK 8'h18
`define WDL_RST_BYTE 8'h00
`define WDL_RST_PINCFG 12'h000
`define WDL_RST_ISTAT 2'b00
`define WDL_RST_IRQS 16'h0000
`define WDL_CTRL_KEEP 8'hEA
`define WDL_BIT_FLAG 0
`define WDL_BIT_LEDTGL 1
`define WDL_BIT_FORCE 2
`define WDL_BIT_UNIT 7
`define WDL_CHAN_OFF 4'h0
`define WDL_GAME_ADDR 12'h201
`define WDL_MIN_LAST 6'h3B
`define WDL_HALF_SEC_MS 500
`define WDL_CLK_KHZ 100000
`define WDL_RESP_OKAY 2'b00
`define WDL_RESP_SLVERR 2'b10
`endif

// ---- core/wdl_pkg.sv ----
// Types shared by the watchdog and power LED block
package wdl_pkg;
  typedef enum logic [1:0] {
    WDL_IDLE = 2'b00,
    WDL_TAKE = 2'b01,
    WDL_RESP = 2'b10
  } wdl_bus_e;
  typedef struct packed {
    logic [3:0] irq_chan;
    logic led_on_to;
    logic mouse_en;
    logic kbd_en;
    logic game_en;
  } wdl_evcfg_s;
  typedef struct packed {
    logic alt_led_pol;
    logic alt_led_alt;
    logic second_pol;
    logic second_alt;
    logic alt46_is_led;
    logic ir_sel;
    logic alt46_pol;
    logic alt46_alt;
    logic led_pol;
    logic led_alt;
    logic st_pol;
    logic st_alt;
  } wdl_pincfg_s;
  typedef struct packed {
    logic status;
    logic led;
    logic alt46;
    logic second;
    logic alt_led;
  } wdl_pins_s;
endpackage

// ---- core/wdl_top.sv ----
// Watchdog timer with power LED control, AXI4-Lite register slave
// Behaviour
// - Time-out of 1 to 255 units, one unit resolution, seconds or minutes.
// - Unit is minutes when bit 7 of decode enable config is set.
// - Reload zero disables the watchdog; zero after reset.
// - Writing nonzero reload loads the count and starts counting down.
// - Count reaching zero halts and sets the time-out status flag.
// - Host may write the status flag to 1 or 0 at any time.
// - Event config bits 0,1,2 enable game port, keyboard, mouse restarts.
// - Enabled restart event reloads the count and clears the flag.
// - Interrupt on flag rise; event config bits 7:4 pick channel, 0 off.
// - Mapped channel request line follows the status flag level.
// - Status pin carries flag when alternate set and IR option clear.
// - Status pins drive flag plain or inverted per polarity bit.
// - Control bit 2 forces count to zero and sets flag; self-clears.
// - Control bit 1 blinks the power LED at 1 Hz, 50 percent.
// - Event config bit 3 blinks the LED while the flag is set.
// - Otherwise the power LED stays asserted.
// - LED asserts low when polarity is 0, high when 1.
// - LED pin drives LED when alternate set and IR clear, IR when both set.
`timescale 1ns/1ps
`include "wdl_regs.svh"
module wdl_top #(
  parameter int unsigned HALF_CYCLES =
    `WDL_HALF_SEC_MS * `WDL_CLK_KHZ
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // System restart events
  input logic kbd_irq_in,
  input logic mouse_irq_in,
  input logic [11:0] io_addr,
  input logic io_rd_strobe,
  input logic io_wr_strobe,
  // Infrared transmit source
  input logic infrared_transmit,
  // Pins
  output logic status_output_pin,
  output logic led_output_pin,
  output logic alt_status_led_pin,
  output logic second_alt_status_pin,
  output logic alt_led_pin,
  // Interrupts
  output logic [15:0] wdt_irq_req,
  output logic irq
);

  function automatic logic [7:0] wmerge(input logic [7:0] old,
                                        input logic [7:0] data,
                                        input logic en);
    wmerge = en ? data : old;
  endfunction

  function automatic logic drive(input logic val, input logic inv);
    drive = inv ? ~val : val;
  endfunction

  // Bus state
  wdl_pkg::wdl_bus_e ws_r, ws_nxt, rs_r, rs_nxt;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Registers
  logic [7:0] reload_r, reload_nxt, ctrl_r, ctrl_nxt;
  logic [7:0] decen_r, decen_nxt;
  wdl_pkg::wdl_evcfg_s evcfg_r, evcfg_nxt;
  wdl_pkg::wdl_pincfg_s pincfg_r, pincfg_nxt;
  logic [1:0] istat_r, istat_nxt, imask_r, imask_nxt;
  // Watchdog state
  logic [7:0] cnt_r, cnt_nxt;
  logic flag_r, flag_nxt;
  logic [5:0] min_r, min_nxt;
  logic [31:0] half_r, half_nxt;
  logic phase_r, phase_nxt;
  logic kbd_d_r, mouse_d_r;
  // Outputs
  wdl_pkg::wdl_pins_s pins_r, pins_nxt;
  logic [15:0] irqs_r, irqs_nxt;
  logic irq_r, irq_nxt;

  logic wr_en, wr_b0, wr_b1, wr_ok;
  logic hit_reload, hit_ctrl, force_to, restart, expire;
  logic half_tick, sec_tick, unit_tick, flag_rise, led_on, led_lvl;
  logic [7:0] pin_hi, mask_w;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign wr_en = (ws_r == wdl_pkg::WDL_TAKE);
  assign wr_b0 = wr_en && s_axi_wstrb[0];
  assign wr_b1 = wr_en && s_axi_wstrb[1];
  assign hit_reload = wr_b0 && (s_axi_awaddr == `WDL_OFF_RELOAD);
  assign hit_ctrl = wr_b0 && (s_axi_awaddr == `WDL_OFF_CTRL);
  assign force_to = hit_ctrl && s_axi_wdata[`WDL_BIT_FORCE];

  // Write channel: wait for both address and data, then respond
  always_comb begin
    ws_nxt = ws_r;
    bresp_nxt = bresp_r;
    case (ws_r)
      wdl_pkg::WDL_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          ws_nxt = wdl_pkg::WDL_TAKE;
        end
      end
      wdl_pkg::WDL_TAKE: begin
        ws_nxt = wdl_pkg::WDL_RESP;
        bresp_nxt = wr_ok ? `WDL_RESP_OKAY : `WDL_RESP_SLVERR;
      end
      wdl_pkg::WDL_RESP: begin
        if (s_axi_bready) begin
          ws_nxt = wdl_pkg::WDL_IDLE;
        end
      end
      default: ws_nxt = wdl_pkg::WDL_IDLE;
    endcase
  end

  // Read channel and read decode
  always_comb begin
    rs_nxt = rs_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rs_r)
      wdl_pkg::WDL_IDLE: begin
        if (s_axi_arvalid) begin
          rs_nxt = wdl_pkg::WDL_TAKE;
        end
      end
      wdl_pkg::WDL_TAKE: begin
        rs_nxt = wdl_pkg::WDL_RESP;
        rresp_nxt = `WDL_RESP_OKAY;
        rdata_nxt = 32'h0000_0000;
        if (s_axi_araddr == `WDL_OFF_RELOAD) begin
          rdata_nxt[7:0] = reload_r;
        end else if (s_axi_araddr == `WDL_OFF_EVCFG) begin
          rdata_nxt[7:0] = evcfg_r;
        end else if (s_axi_araddr == `WDL_OFF_CTRL) begin
          // Force bit always reads back zero
          rdata_nxt[7:0] = ctrl_r | {7'h00, flag_r};
        end else if (s_axi_araddr == `WDL_OFF_DECEN) begin
          rdata_nxt[7:0] = decen_r;
        end else if (s_axi_araddr == `WDL_OFF_PINCFG) begin
          rdata_nxt[11:0] = pincfg_r;
        end else if (s_axi_araddr == `WDL_OFF_ISTAT) begin
          rdata_nxt[1:0] = istat_r;
        end else if (s_axi_araddr == `WDL_OFF_IMASK) begin
          rdata_nxt[1:0] = imask_r;
        end else begin
          rresp_nxt = `WDL_RESP_SLVERR;
        end
      end
      wdl_pkg::WDL_RESP: begin
        if (s_axi_rready) begin
          rs_nxt = wdl_pkg::WDL_IDLE;
        end
      end
      default: rs_nxt = wdl_pkg::WDL_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_r <= wdl_pkg::WDL_IDLE;
      rs_r <= wdl_pkg::WDL_IDLE;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `WDL_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `WDL_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      ws_r <= ws_nxt;
      rs_r <= rs_nxt;
      awready_r <= (ws_nxt == wdl_pkg::WDL_TAKE);
      wready_r <= (ws_nxt == wdl_pkg::WDL_TAKE);
      bvalid_r <= (ws_nxt == wdl_pkg::WDL_RESP);
      bresp_r <= bresp_nxt;
      arready_r <= (rs_nxt == wdl_pkg::WDL_TAKE);
      rvalid_r <= (rs_nxt == wdl_pkg::WDL_RESP);
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Register writes other than the watchdog count, flag and interrupt status
  always_comb begin
    reload_nxt = reload_r;
    evcfg_nxt = evcfg_r;
    ctrl_nxt = ctrl_r;
    decen_nxt = decen_r;
    pincfg_nxt = pincfg_r;
    imask_nxt = imask_r;
    wr_ok = 1'b1;
    pin_hi = 8'h00;
    mask_w = 8'h00;
    if (s_axi_awaddr == `WDL_OFF_RELOAD) begin
      reload_nxt = wmerge(reload_r, s_axi_wdata[7:0], wr_b0);
    end else if (s_axi_awaddr == `WDL_OFF_EVCFG) begin
      evcfg_nxt = wmerge(evcfg_r, s_axi_wdata[7:0], wr_b0);
    end else if (s_axi_awaddr == `WDL_OFF_CTRL) begin
      ctrl_nxt = wmerge(ctrl_r, s_axi_wdata[7:0] & `WDL_CTRL_KEEP,
                        wr_b0);
    end else if (s_axi_awaddr == `WDL_OFF_DECEN) begin
      decen_nxt = wmerge(decen_r, s_axi_wdata[7:0], wr_b0);
    end else if (s_axi_awaddr == `WDL_OFF_PINCFG) begin
      pincfg_nxt[7:0] = wmerge(pincfg_r[7:0], s_axi_wdata[7:0], wr_b0);
      pin_hi = wmerge({4'h0, pincfg_r[11:8]}, s_axi_wdata[15:8], wr_b1);
      pincfg_nxt[11:8] = pin_hi[3:0];
    end else if (s_axi_awaddr == `WDL_OFF_IMASK) begin
      mask_w = wmerge({6'h00, imask_r}, s_axi_wdata[7:0], wr_b0);
      imask_nxt = mask_w[1:0];
    end else if (s_axi_awaddr != `WDL_OFF_ISTAT) begin
      wr_ok = 1'b0;
    end
  end

  // Prescaler: half-second ticks, seconds on every second one
  assign half_tick = (half_r == HALF_CYCLES - 32'd1);
  assign sec_tick = half_tick && phase_r;
  assign unit_tick = decen_r[`WDL_BIT_UNIT] ?
                     (sec_tick && min_r == `WDL_MIN_LAST) :
                     sec_tick;

  // Restart sources, interrupt inputs taken on their rising edge
  assign restart = (evcfg_r.game_en && (io_rd_strobe || io_wr_strobe)
                    && io_addr == `WDL_GAME_ADDR) ||
                   (evcfg_r.kbd_en && kbd_irq_in && !kbd_d_r) ||
                   (evcfg_r.mouse_en && mouse_irq_in && !mouse_d_r);

  always_comb begin
    cnt_nxt = cnt_r;
    flag_nxt = flag_r;
    min_nxt = min_r;
    expire = 1'b0;
    half_nxt = half_tick ? 32'h0000_0000 : half_r + 32'd1;
    phase_nxt = half_tick ? ~phase_r : phase_r;
    if (sec_tick) begin
      min_nxt = (min_r == `WDL_MIN_LAST) ? 6'h00 : min_r + 6'd1;
    end
    if (hit_reload) begin
      cnt_nxt = s_axi_wdata[7:0];
      min_nxt = 6'h00;
    end else if (restart) begin
      cnt_nxt = reload_r;
      flag_nxt = 1'b0;
      min_nxt = 6'h00;
    end else if (unit_tick && cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'd1;
      expire = (cnt_r == 8'h01);
    end
    if (hit_ctrl) begin
      flag_nxt = s_axi_wdata[`WDL_BIT_FLAG];
    end
    // Hardware set wins over a host clear in the same cycle
    if (force_to) begin
      cnt_nxt = 8'h00;
      flag_nxt = 1'b1;
    end
    if (expire) begin
      flag_nxt = 1'b1;
    end
  end

  // Sticky events: bit 0 time-out rise, bit 1 restart
  assign flag_rise = flag_nxt && !flag_r;
  always_comb begin
    istat_nxt = istat_r;
    if (wr_b0 && s_axi_awaddr == `WDL_OFF_ISTAT) begin
      istat_nxt = istat_r & ~s_axi_wdata[1:0];
    end
    istat_nxt = istat_nxt | {restart, flag_rise};
    irq_nxt = |(istat_r & imask_r);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= `WDL_RST_BYTE;
      evcfg_r <= `WDL_RST_BYTE;
      ctrl_r <= `WDL_RST_BYTE;
      decen_r <= `WDL_RST_BYTE;
      pincfg_r <= `WDL_RST_PINCFG;
      istat_r <= `WDL_RST_ISTAT;
      imask_r <= `WDL_RST_ISTAT;
      cnt_r <= `WDL_RST_BYTE;
      flag_r <= 1'b0;
      min_r <= 6'h00;
      half_r <= 32'h0000_0000;
      phase_r <= 1'b0;
      kbd_d_r <= 1'b0;
      mouse_d_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (wr_en) begin
        reload_r <= reload_nxt;
        evcfg_r <= evcfg_nxt;
        ctrl_r <= ctrl_nxt;
        decen_r <= decen_nxt;
        pincfg_r <= pincfg_nxt;
        imask_r <= imask_nxt;
      end
      istat_r <= istat_nxt;
      cnt_r <= cnt_nxt;
      flag_r <= flag_nxt;
      min_r <= min_nxt;
      half_r <= half_nxt;
      phase_r <= phase_nxt;
      kbd_d_r <= kbd_irq_in;
      mouse_d_r <= mouse_irq_in;
      irq_r <= irq_nxt;
    end
  end

  // LED and pin drive; pins not in alternate function idle low
  assign led_on = ctrl_r[`WDL_BIT_LEDTGL] ||
                  (evcfg_r.led_on_to && flag_r) ?
                  phase_r : 1'b1;
  assign led_lvl = pincfg_r.led_pol ? led_on : ~led_on;

  always_comb begin
    pins_nxt = '0;
    irqs_nxt = `WDL_RST_IRQS;
    if (pincfg_r.st_alt && !pincfg_r.ir_sel) begin
      pins_nxt.status = drive(flag_r, pincfg_r.st_pol);
    end
    if (pincfg_r.led_alt) begin
      pins_nxt.led = pincfg_r.ir_sel ? infrared_transmit :
                     led_lvl;
    end
    if (pincfg_r.alt46_alt) begin
      pins_nxt.alt46 = pincfg_r.alt46_is_led ?
        (pincfg_r.alt46_pol ? led_on : ~led_on) :
        drive(flag_r, pincfg_r.alt46_pol);
    end
    if (pincfg_r.second_alt) begin
      pins_nxt.second = drive(flag_r, pincfg_r.second_pol);
    end
    if (pincfg_r.alt_led_alt) begin
      pins_nxt.alt_led = pincfg_r.alt_led_pol ? led_on : ~led_on;
    end
    if (evcfg_r.irq_chan != `WDL_CHAN_OFF) begin
      irqs_nxt[evcfg_r.irq_chan] = flag_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_r <= '0;
      irqs_r <= `WDL_RST_IRQS;
    end else begin
      pins_r <= pins_nxt;
      irqs_r <= irqs_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign status_output_pin = pins_r.status;
  assign led_output_pin = pins_r.led;
  assign alt_status_led_pin = pins_r.alt46;
  assign second_alt_status_pin = pins_r.second;
  assign alt_led_pin = pins_r.alt_led;
  assign wdt_irq_req = irqs_r;
  assign irq = irq_r;

  chk_zero_disable: assert property (
    reload_r == 8'h00 |-> cnt_r == 8'h00)
    else $error("count nonzero while disabled");
  chk_reload_load: assert property (
    hit_reload && !force_to |=> cnt_r == $past(s_axi_wdata[7:0]))
    else $error("reload write did not load count");
  chk_expire_flag: assert property (
    unit_tick && cnt_r == 8'h01 && !hit_reload && !restart
    |=> flag_r && cnt_r == 8'h00)
    else $error("expiry did not set flag");
  chk_count_halt: assert property (
    cnt_r == 8'h00 && !hit_reload && !restart |=> cnt_r == 8'h00)
    else $error("count moved after reaching zero");
  chk_host_flag: assert property (
    hit_ctrl && !force_to && !expire
    |=> flag_r == $past(s_axi_wdata[0]))
    else $error("host flag write lost");
  chk_restart_load: assert property (
    restart && !hit_reload && !hit_ctrl && !force_to
    |=> cnt_r == $past(reload_r) && !flag_r)
    else $error("restart did not reload");
  chk_chan_follow: assert property (
    evcfg_r.irq_chan != 4'h0 && $stable(evcfg_r)
    |=> wdt_irq_req[$past(evcfg_r.irq_chan)] == $past(flag_r))
    else $error("irq channel not following flag");
  chk_status_pol: assert property (
    pincfg_r.st_alt && !pincfg_r.ir_sel
    |=> status_output_pin == $past(flag_r ^ pincfg_r.st_pol))
    else $error("status pin polarity wrong");
  chk_force_sets: assert property (
    force_to |=> flag_r && cnt_r == 8'h00 && ctrl_r[2] == 1'b0)
    else $error("force did not time out");
  chk_led_steady: assert property (
    !ctrl_r[1] && !(evcfg_r.led_on_to && flag_r) &&
    pincfg_r.led_alt && !pincfg_r.ir_sel
    |=> led_output_pin == $past(pincfg_r.led_pol))
    else $error("led not steadily asserted");
  chk_irq_level: assert property (
    ##1 irq == $past(|(istat_r & imask_r)))
    else $error("irq output mismatch");
  cov_expire: cover property (expire);
  cov_restart: cover property (restart && flag_r);
  cov_force: cover property (force_to);
  cov_blink: cover property (ctrl_r[1] && half_tick);
endmodule

// ---- dv/wdl_events.sv ----
// Model of the keyboard, mouse, game port and infrared sources
`timescale 1ns/1ps
`include "wdl_regs.svh"
module wdl_events (
  // Clock
  input wire logic aclk,
  // Event lines
  output logic kbd_irq_in,
  output logic mouse_irq_in,
  output logic [11:0] io_addr,
  output logic io_rd_strobe,
  output logic io_wr_strobe,
  // Infrared source
  output logic infrared_transmit
);
  logic [11:0] addr_r = 12'h000;
  logic [11:0] noise_r = 12'h000;
  // Idle address wanders so a stale game-port match cannot pass
  assign io_addr = (io_rd_strobe | io_wr_strobe) ? addr_r : noise_r;
  always @(posedge aclk) begin
    noise_r <= noise_r + 12'h0A5;
  end
  initial begin
    kbd_irq_in = 1'b0;
    mouse_irq_in = 1'b0;
    io_rd_strobe = 1'b0;
    io_wr_strobe = 1'b0;
    infrared_transmit = 1'b0;
  end
  // One event: 0 game port access, 1 keyboard, 2 mouse
  task automatic fire(input int k);
    @(posedge aclk);
    case (k)
      0: begin
        addr_r <= `WDL_GAME_ADDR;
        {io_rd_strobe, io_wr_strobe} <= 2'($urandom_range(1, 2));
      end
      1: kbd_irq_in <= 1'b1;
      default: mouse_irq_in <= 1'b1;
    endcase
    @(posedge aclk);
    {io_rd_strobe, io_wr_strobe} <= 2'b00;
    kbd_irq_in <= 1'b0;
    mouse_irq_in <= 1'b0;
  endtask
  task automatic ir(input logic v);
    @(posedge aclk);
    infrared_transmit <= v;
  endtask
endmodule

// ---- dv/watchdog_power_led_control_bench.sv ----
// Self-checking bench for the watchdog and power LED block
`timescale 1ns/1ps
`include "wdl_regs.svh"
module watchdog_power_led_control_bench;
  localparam int HC = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic kbd_irq_in, mouse_irq_in, io_rd_strobe, io_wr_strobe;
  logic infrared_transmit;
  logic [11:0] io_addr;
  logic [15:0] wdt_irq_req;
  wire [5:0] pv;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] rl;
  logic [3:0] ch;
  int n_errors = 0;
  int n_tests = 0;
  always #5 aclk = ~aclk;
  wdl_top #(.HALF_CYCLES(HC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .kbd_irq_in(kbd_irq_in),
    .mouse_irq_in(mouse_irq_in), .io_addr(io_addr),
    .io_rd_strobe(io_rd_strobe), .io_wr_strobe(io_wr_strobe),
    .infrared_transmit(infrared_transmit), .status_output_pin(pv[0]),
    .led_output_pin(pv[1]), .alt_status_led_pin(pv[4]),
    .second_alt_status_pin(pv[2]), .alt_led_pin(pv[5]),
    .wdt_irq_req(wdt_irq_req), .irq(pv[3]));
  wdl_events ev (.aclk(aclk), .kbd_irq_in(kbd_irq_in),
    .mouse_irq_in(mouse_irq_in), .io_addr(io_addr),
    .io_rd_strobe(io_rd_strobe), .io_wr_strobe(io_wr_strobe),
    .infrared_transmit(infrared_transmit));
  task automatic note(input logic ok, input logic [33:0] g, e);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bus(input logic [33:0] g, e);
    note(g === e, g, e);
  endtask
  task automatic cmp_resp(input logic [1:0] g, e);
    note(g === e, 34'(g), 34'(e));
  endtask
  task automatic cmp_out(input logic [15:0] g, e);
    note(g === e, 34'(g), 34'(e));
  endtask
  // Ready lines stay high, so each valid is one handshake
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && rq.size() > 0)
      cmp_bus({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && bq.size() > 0)
      cmp_resp(s_axi_bresp, bq.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `WDL_RESP_OKAY);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `WDL_RESP_OKAY);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask
  task automatic wait_pin(input int i, input logic v, input int n);
    while (pv[i] !== v && n > 0) begin
      @(posedge aclk);
      n--;
    end
    cmp_out(16'(pv[i]), 16'(v));
  endtask
  task automatic pin_is(input int i, input logic v);
    repeat (3) @(posedge aclk);
    cmp_out(16'(pv[i]), 16'(v));
  endtask
  // Length of one LED phase, bounded so a stuck pin cannot hang
  task automatic blink(input int e);
    logic v;
    int n;
    n = 0;
    repeat (2) @(posedge aclk);
    v = pv[1];
    while (pv[1] === v && n < 20) begin
      @(posedge aclk);
      n++;
    end
    v = pv[1];
    n = 0;
    while (pv[1] === v && n < 20) begin
      @(posedge aclk);
      n++;
    end
    cmp_out(16'(n), 16'(e));
  endtask
  task automatic complete_run();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    void'($urandom(51));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`WDL_OFF_RELOAD, 32'h0000_0000);
    rd(`WDL_OFF_CTRL, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000, `WDL_RESP_SLVERR);
    wr(8'h1C, 32'h0000_00FF, `WDL_RESP_SLVERR);
    wr(`WDL_OFF_PINCFG, 32'h0000_0305);
    repeat (40) @(posedge aclk);
    pin_is(0, 1'b0);
    pin_is(2, 1'b1);
    $display("reset test done");
    rl = 8'($urandom_range(2, 4));
    wr(`WDL_OFF_RELOAD, {24'h00_0000, rl});
    repeat ((rl - 1) * 8 - 2) @(posedge aclk);
    cmp_out(16'(pv[0]), 16'h0000);
    wait_pin(0, 1'b1, 24);
    pin_is(2, 1'b0);
    rd(`WDL_OFF_CTRL, 32'h0000_0001);
    s_axi_wstrb <= 4'h0;
    wr(`WDL_OFF_RELOAD, 32'h0000_0009);
    s_axi_wstrb <= 4'hF;
    rd(`WDL_OFF_RELOAD, {24'h00_0000, rl});
    rd(`WDL_OFF_ISTAT, 32'h0000_0001);
    pin_is(3, 1'b0);
    wr(`WDL_OFF_IMASK, 32'h0000_0001);
    pin_is(3, 1'b1);
    wr(`WDL_OFF_IMASK, 32'h0000_0000);
    wr(`WDL_OFF_ISTAT, 32'h0000_0003);
    pin_is(3, 1'b0);
    rd(`WDL_OFF_ISTAT, 32'h0000_0000);
    $display("expiry test done");
    wr(`WDL_OFF_CTRL, 32'h0000_0000);
    pin_is(0, 1'b0);
    wr(`WDL_OFF_CTRL, 32'h0000_0004);
    pin_is(0, 1'b1);
    rd(`WDL_OFF_CTRL, 32'h0000_0001);
    wr(`WDL_OFF_CTRL, 32'h0000_0000);
    pin_is(0, 1'b0);
    ch = 4'($urandom_range(1, 15));
    wr(`WDL_OFF_EVCFG, {24'h00_0000, ch, 4'h0});
    wr(`WDL_OFF_CTRL, 32'h0000_0001);
    pin_is(0, 1'b1);
    cmp_out(wdt_irq_req, 16'h0001 << ch);
    wr(`WDL_OFF_EVCFG, 32'h0000_0000);
    pin_is(0, 1'b1);
    cmp_out(wdt_irq_req, 16'h0000);
    $display("flag test done");
    wr(`WDL_OFF_RELOAD, 32'h0000_00C8);
    for (int i = 0; i < 3; i++) begin
      wr(`WDL_OFF_EVCFG, 32'h0000_0001 << i);
      wr(`WDL_OFF_CTRL, 32'h0000_0001);
      ev.fire((i + 1) % 3);
      pin_is(0, 1'b1);
      ev.fire(i);
      pin_is(0, 1'b0);
    end
    wr(`WDL_OFF_EVCFG, 32'h0000_0000);
    $display("restart test done");
    wr(`WDL_OFF_DECEN, 32'h0000_0080);
    wr(`WDL_OFF_RELOAD, 32'h0000_0001);
    wr(`WDL_OFF_CTRL, 32'h0000_0000);
    repeat (400) @(posedge aclk);
    cmp_out(16'(pv[0]), 16'h0000);
    wait_pin(0, 1'b1, 150);
    wr(`WDL_OFF_DECEN, 32'h0000_0000);
    $display("minute test done");
    pin_is(1, 1'b0);
    wr(`WDL_OFF_PINCFG, 32'h0000_030D);
    pin_is(1, 1'b1);
    wr(`WDL_OFF_CTRL, 32'h0000_0003);
    blink(HC);
    wr(`WDL_OFF_CTRL, 32'h0000_0001);
    wr(`WDL_OFF_EVCFG, 32'h0000_0008);
    blink(HC);
    wr(`WDL_OFF_CTRL, 32'h0000_0000);
    pin_is(1, 1'b1);
    wr(`WDL_OFF_PINCFG, 32'h0000_0FBD);
    pin_is(4, 1'b1);
    pin_is(5, 1'b1);
    wr(`WDL_OFF_CTRL, 32'h0000_0001);
    wr(`WDL_OFF_PINCFG, 32'h0000_031F);
    pin_is(0, 1'b0);
    pin_is(4, 1'b1);
    wr(`WDL_OFF_PINCFG, 32'h0000_034D);
    ev.ir(1'b1);
    pin_is(1, 1'b1);
    ev.ir(1'b0);
    pin_is(1, 1'b0);
    pin_is(0, 1'b0);
    $display("led test done");
    complete_run();
  end
endmodule
